// *** common/rgal_cfg_if.sv ***
// Carries the three stored control registers from the register file to the decoders.
// Assumes one clock domain; the holder drives, the decoders only read.
`timescale 1ns/1ps
`default_nettype none
interface rgal_cfg_if;
	rgal_pkg::rgal_byte_t rgb2;
	rgal_pkg::rgal_byte_t aud1;
	rgal_pkg::rgal_byte_t aud2;

	modport holder (output rgb2, output aud1, output aud2);
	modport reader (input rgb2, input aud1, input aud2);
endinterface
`default_nettype wire

// *** common/rgal_defs.svh ***
// Register map, field positions and reset values of the RGB2 / audio control slice.
// Assumes a 32-bit AHB-Lite bus; each 8-bit register sits in the low byte of one word.
`ifndef RGAL_DEFS_SVH
`define RGAL_DEFS_SVH

// Register indices; byte address is four times the index
`define RGAL_IDX_RGB2       8'h13
`define RGAL_IDX_AUD1       8'h2A
`define RGAL_IDX_AUD2       8'h2B
`define RGAL_IDX_STAT       8'h30

// Reset values
`define RGAL_RST_RGB2       8'h00
`define RGAL_RST_AUD1       8'h03
`define RGAL_RST_AUD2       8'h00

// Writable bits of the second audio register
`define RGAL_AUD2_WMASK     8'h1F

// Field positions, current ceilings
`define RGAL_RED_HI         5
`define RGAL_RED_LO         4
`define RGAL_GREEN_HI       3
`define RGAL_GREEN_LO       2
`define RGAL_BLUE_HI        1
`define RGAL_BLUE_LO        0

// Field positions, first audio register
`define RGAL_GAIN_HI        7
`define RGAL_GAIN_LO        5
`define RGAL_FREQ_MODE_BIT  4
`define RGAL_AGC_BIT        3
`define RGAL_SYNC_BIT       2
`define RGAL_SRC_HI         1
`define RGAL_SRC_LO         0

// Field positions, second audio register
`define RGAL_AVG_BIT        4
`define RGAL_FILT_HI        3
`define RGAL_FILT_LO        2
`define RGAL_SPEED_HI       1
`define RGAL_SPEED_LO       0

// Gain step per code, in dB
`define RGAL_GAIN_STEP_DB   5'h03

`endif

// *** common/rgal_pkg.sv ***
// Types shared by the RGB2 / audio control slice.
// Assumes the constants of rgal_defs.svh for positions and values.
package rgal_pkg;

	typedef logic [7:0] rgal_byte_t;

	typedef enum logic [1:0] {
		RGAL_SRC_AUDIO   = 2'b00,
		RGAL_SRC_TEMP    = 2'b01,
		RGAL_SRC_AMBIENT = 2'b10,
		RGAL_SRC_NONE    = 2'b11
	} rgal_adc_src_t;

	typedef enum logic [1:0] {
		RGAL_SPEED_FASTEST = 2'b00,
		RGAL_SPEED_FAST    = 2'b01,
		RGAL_SPEED_MEDIUM  = 2'b10,
		RGAL_SPEED_SLOW    = 2'b11
	} rgal_speed_t;

	typedef enum logic [1:0] {
		RGAL_HTRANS_IDLE   = 2'b00,
		RGAL_HTRANS_BUSY   = 2'b01,
		RGAL_HTRANS_NONSEQ = 2'b10,
		RGAL_HTRANS_SEQ    = 2'b11
	} rgal_htrans_t;

endpackage

// *** src/rgal_audio_dec.sv ***
// Decodes the gain code into dB and the converter source into one-hot selects.
// Assumes the stored registers reach it through rgal_cfg_if; one clock, async reset.
`include "rgal_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rgal_audio_dec (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	rgal_cfg_if.reader        cfg,
	output var  logic [4:0]   o_gain_db,
	output var  logic [3:0]   o_src_onehot
);
	wire logic [2:0]          gain_code;
	wire rgal_pkg::rgal_adc_src_t src;
	wire logic [4:0]          next_gain_db;
	wire logic [3:0]          next_src_onehot;

	assign gain_code       = cfg.aud1[`RGAL_GAIN_HI:`RGAL_GAIN_LO];
	assign src             = rgal_pkg::rgal_adc_src_t'(cfg.aud1[`RGAL_SRC_HI:`RGAL_SRC_LO]);
	// 3 dB per code step, 0 to 21 dB
	assign next_gain_db    = 5'({2'b00, gain_code} * `RGAL_GAIN_STEP_DB);
	// Bit 0 audio pin, 1 temperature, 2 ambient light, 3 nothing
	assign next_src_onehot = 4'h1 << src;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_gain_db    <= 5'h00;
			o_src_onehot <= 4'h8;
		end else begin
			o_gain_db    <= next_gain_db;
			o_src_onehot <= next_src_onehot;
		end
	end
endmodule // rgal_audio_dec
`default_nettype wire

// *** src/rgal_ceiling_dec.sv ***
// Turns the three 2-bit ceiling codes into a count of quarters of full scale.
// Assumes the stored register reaches it through rgal_cfg_if; one clock, async reset.
`include "rgal_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rgal_ceiling_dec (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	rgal_cfg_if.reader        cfg,
	output var  logic [2:0]   o_quarters [3]
);
	// Index 0 blue, 1 green, 2 red; each field is two bits wide
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_colour
			wire logic [1:0] code;
			wire logic [2:0] next_quarters;
			assign code          = cfg.rgb2[2*g+1 -: 2];
			assign next_quarters = {1'b0, code} + 3'h1;
			always_ff @(posedge i_ref_clk or posedge i_rst) begin
				if (i_rst) begin
					o_quarters[g] <= 3'h1;
				end else begin
					o_quarters[g] <= next_quarters;
				end
			end
		end
	endgenerate
endmodule // rgal_ceiling_dec
`default_nettype wire

// *** src/rgal_top.sv ***
// RGB2 current ceilings and audio / converter control registers behind an AHB-Lite slave.
// Assumes a single AHB-Lite master, word transfers, one clock and async active-high reset.
//
// Functional notes
// - The red group-2 ceiling is bits 5:4 of the current register, 00..11 giving 1..4 quarters.
// - The green group-2 ceiling is bits 3:2, 00..11 giving quarter steps up to full scale.
// - The blue group-2 ceiling is bits 1:0, 00..11 giving quarter steps up to full scale.
// - Audio register one bits 7:5 hold the gain code, 3 dB per step from 0 dB to 21 dB.
// - Audio register one bit 4 picks amplitude-following (0) or frequency-following (1).
// - Audio register one bit 3 enables automatic gain control when set.
// - Audio register one bit 2 enables audio synchronisation of the colour LEDs when set.
// - Audio register one bits 1:0 pick audio pin, temperature, ambient light or none (reset).
// - Audio register two bit 4 enables averaging of the audio or converter signal when set.
// - Audio register two bits 3:2 hold the filtering scheme code.
// - Audio register two bits 1:0 set LED response speed, fastest at reset to slow.
`include "rgal_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rgal_top (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst,
	// AHB-Lite slave
	input  wire logic         i_hsel,
	input  wire logic [31:0]  i_haddr,
	input  wire logic [1:0]   i_htrans,
	input  wire logic         i_hwrite,
	input  wire logic [2:0]   i_hsize,
	input  wire logic [31:0]  i_hwdata,
	input  wire logic         i_hready,
	output var  logic [31:0]  o_hrdata,
	output var  logic         o_hreadyout,
	output var  logic         o_hresp,
	// Current ceilings, raw codes
	output var  logic [1:0]   o_red_group2_ceiling,
	output var  logic [1:0]   o_green_group2_ceiling,
	output var  logic [1:0]   o_blue_group2_ceiling,
	// Current ceilings, quarters of full scale (1..4)
	output var  logic [2:0]   o_red_group2_quarters,
	output var  logic [2:0]   o_green_group2_quarters,
	output var  logic [2:0]   o_blue_group2_quarters,
	// Audio path controls
	output var  logic [2:0]   o_gain_code,
	output var  logic [4:0]   o_gain_db,
	output var  logic         o_freq_mode,
	output var  logic         o_agc_enable,
	output var  logic         o_sync_enable,
	output var  logic [1:0]   o_adc_source,
	output var  logic         o_sel_single_ended_audio_pin,
	output var  logic         o_sel_temperature,
	output var  logic         o_sel_ambient_light,
	output var  logic         o_avg_enable,
	output var  logic [1:0]   o_filter_scheme,
	output var  logic [1:0]   o_response_speed
);

	// Stored registers
	rgal_pkg::rgal_byte_t     rgb2;
	rgal_pkg::rgal_byte_t     aud1;
	rgal_pkg::rgal_byte_t     aud2;

	// Data-phase state latched from the address phase
	logic                     dp_write;
	logic [7:0]               dp_idx;

	// Decoder outputs
	logic [2:0]               quarters [3];
	logic [4:0]               gain_db;
	logic [3:0]               src_onehot;

	// Address-phase decode
	wire logic                ap_valid;
	wire logic                ap_aligned;
	wire logic [7:0]          ap_idx;
	wire logic                ap_read;

	// Data-phase write strobes
	wire logic                wr_rgb2;
	wire logic                wr_aud1;
	wire logic                wr_aud2;
	wire logic [7:0]          wdata;

	// Next register values
	wire rgal_pkg::rgal_byte_t next_rgb2;
	wire rgal_pkg::rgal_byte_t next_aud1;
	wire rgal_pkg::rgal_byte_t next_aud2;
	wire logic [7:0]          stat_byte;
	wire logic [7:0]          rd_byte;
	wire logic [31:0]         next_hrdata;

	rgal_cfg_if cfg ();

	assign cfg.rgb2 = rgb2;
	assign cfg.aud1 = aud1;
	assign cfg.aud2 = aud2;

	// ---------------- Address phase ----------------
	assign ap_valid   = i_hsel & i_htrans[1] & i_hready;
	assign ap_aligned = (i_haddr[31:10] == 22'h00_0000) & (i_haddr[1:0] == 2'b00);
	// Unmapped or misaligned addresses decode to an index nothing answers to
	assign ap_idx     = ap_aligned ? i_haddr[9:2] : 8'hFF;
	assign ap_read    = ap_valid & ~i_hwrite;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			dp_write <= 1'b0;
			dp_idx   <= 8'hFF;
		end else if (i_hready) begin
			dp_write <= ap_valid & i_hwrite;
			dp_idx   <= ap_idx;
		end
	end

	// ---------------- Data phase writes ----------------
	assign wdata   = i_hwdata[7:0];
	assign wr_rgb2 = dp_write & (dp_idx == `RGAL_IDX_RGB2);
	assign wr_aud1 = dp_write & (dp_idx == `RGAL_IDX_AUD1);
	assign wr_aud2 = dp_write & (dp_idx == `RGAL_IDX_AUD2);

	assign next_rgb2 = wr_rgb2 ? wdata : rgb2;
	assign next_aud1 = wr_aud1 ? wdata : aud1;
	// Upper three bits never store
	assign next_aud2 = wr_aud2 ? (wdata & `RGAL_AUD2_WMASK) : aud2;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rgb2 <= `RGAL_RST_RGB2;
			aud1 <= `RGAL_RST_AUD1;
			aud2 <= `RGAL_RST_AUD2;
		end else begin
			rgb2 <= next_rgb2;
			aud1 <= next_aud1;
			aud2 <= next_aud2;
		end
	end

	// ---------------- Reads ----------------
	// Applied state: gain in dB and the active converter source
	// One-hot back to the two-bit source code; none reads as 11
	assign stat_byte = {1'b0, gain_db[4:0], src_onehot[2] | src_onehot[3],
		src_onehot[1] | src_onehot[3]};

	// Next values are used so a read right behind a write sees the new data
	assign rd_byte =
		(ap_idx == `RGAL_IDX_RGB2) ? next_rgb2 :
		(ap_idx == `RGAL_IDX_AUD1) ? next_aud1 :
		(ap_idx == `RGAL_IDX_AUD2) ? next_aud2 :
		(ap_idx == `RGAL_IDX_STAT) ? stat_byte :
		8'h00;

	assign next_hrdata = ap_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hrdata    <= 32'h0000_0000;
			o_hreadyout <= 1'b0;
			o_hresp     <= 1'b0;
		end else begin
			if (i_hready) begin
				o_hrdata <= next_hrdata;
			end
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
	end

	// ---------------- Decoders ----------------
	rgal_ceiling_dec u_ceiling_dec (
		.i_ref_clk  (i_ref_clk),
		.i_rst      (i_rst),
		.cfg        (cfg),
		.o_quarters (quarters)
	);

	rgal_audio_dec u_audio_dec (
		.i_ref_clk    (i_ref_clk),
		.i_rst        (i_rst),
		.cfg          (cfg),
		.o_gain_db    (gain_db),
		.o_src_onehot (src_onehot)
	);

	// ---------------- Outputs, all straight from flip-flops ----------------
	assign o_red_group2_ceiling   = rgb2[`RGAL_RED_HI:`RGAL_RED_LO];
	assign o_green_group2_ceiling = rgb2[`RGAL_GREEN_HI:`RGAL_GREEN_LO];
	assign o_blue_group2_ceiling  = rgb2[`RGAL_BLUE_HI:`RGAL_BLUE_LO];

	assign o_red_group2_quarters   = quarters[2];
	assign o_green_group2_quarters = quarters[1];
	assign o_blue_group2_quarters  = quarters[0];

	assign o_gain_code   = aud1[`RGAL_GAIN_HI:`RGAL_GAIN_LO];
	assign o_gain_db     = gain_db;
	assign o_freq_mode   = aud1[`RGAL_FREQ_MODE_BIT];
	assign o_agc_enable  = aud1[`RGAL_AGC_BIT];
	assign o_sync_enable = aud1[`RGAL_SYNC_BIT];
	assign o_adc_source  = aud1[`RGAL_SRC_HI:`RGAL_SRC_LO];

	assign o_sel_single_ended_audio_pin = src_onehot[0];
	assign o_sel_temperature            = src_onehot[1];
	assign o_sel_ambient_light          = src_onehot[2];

	assign o_avg_enable     = aud2[`RGAL_AVG_BIT];
	assign o_filter_scheme  = aud2[`RGAL_FILT_HI:`RGAL_FILT_LO];
	assign o_response_speed = aud2[`RGAL_SPEED_HI:`RGAL_SPEED_LO];

	// Size of a transfer is not checked: only the low byte lane carries data
	wire logic unused_ok;
	assign unused_ok = &{1'b0, i_hsize, i_hwdata[31:8]};

endmodule // rgal_top
`default_nettype wire

// *** test/rgal_top_properties.sv ***
// Checker for rgal_top: decode latency, write effects and read-zero bits.
// Assumes it is bound into rgal_top; one clock, async active-high reset.
`include "rgal_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rgal_top_check (
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	input wire logic        i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0]  i_htrans,
	input wire logic        i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic        i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic [1:0]  o_red_group2_ceiling,
	input wire logic [1:0]  o_green_group2_ceiling,
	input wire logic [1:0]  o_blue_group2_ceiling,
	input wire logic [2:0]  o_red_group2_quarters,
	input wire logic [2:0]  o_green_group2_quarters,
	input wire logic [2:0]  o_blue_group2_quarters,
	input wire logic [2:0]  o_gain_code,
	input wire logic [4:0]  o_gain_db,
	input wire logic [1:0]  o_adc_source,
	input wire logic        o_sel_single_ended_audio_pin,
	input wire logic        o_sel_temperature,
	input wire logic        o_sel_ambient_light
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	wire       take = i_hsel && i_htrans[1] && i_hready;
	wire [2:0] wg   = i_hwdata[7:5];
	wire [1:0] ws   = i_hwdata[1:0];
	wire [5:0] wc   = i_hwdata[5:0];
	wire       wr0  = take && i_hwrite && i_haddr == {22'h0, `RGAL_IDX_RGB2, 2'b00};
	wire       wr1  = take && i_hwrite && i_haddr == {22'h0, `RGAL_IDX_AUD1, 2'b00};
	wire       rd2  = take && !i_hwrite && i_haddr == {22'h0, `RGAL_IDX_AUD2, 2'b00};

	a_red_quarters: assert property (
		o_red_group2_quarters == $past(o_red_group2_ceiling) + 3'd1) else $error("red quarters");
	a_green_quarters: assert property (
		o_green_group2_quarters == $past(o_green_group2_ceiling) + 3'd1) else $error("green quarters");
	a_blue_quarters: assert property (
		o_blue_group2_quarters == $past(o_blue_group2_ceiling) + 3'd1) else $error("blue quarters");
	a_gain_db: assert property (o_gain_db == $past(o_gain_code) * 5'd3)
		else $error("gain in dB");
	a_source_onehot: assert property (
		{o_sel_ambient_light, o_sel_temperature, o_sel_single_ended_audio_pin} ==
		($past(o_adc_source) == 2'b11 ? 3'b000 : 3'b001 << $past(o_adc_source)))
		else $error("source selects");
	a_ceiling_write: assert property (
		wr0 |=> ##1 {o_red_group2_ceiling, o_green_group2_ceiling, o_blue_group2_ceiling} == $past(wc))
		else $error("ceiling write");
	a_audio_write: assert property (
		wr1 |=> ##1 o_gain_code == $past(wg) && o_adc_source == $past(ws)) else $error("audio write");
	a_unused_zero: assert property (rd2 |=> o_hrdata[31:5] == 27'h0)
		else $error("unused bits read");
endmodule // rgal_top_check

bind rgal_top rgal_top_check u_check (
	.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.o_hrdata(o_hrdata), .o_red_group2_ceiling(o_red_group2_ceiling),
	.o_green_group2_ceiling(o_green_group2_ceiling), .o_blue_group2_ceiling(o_blue_group2_ceiling),
	.o_red_group2_quarters(o_red_group2_quarters), .o_green_group2_quarters(o_green_group2_quarters),
	.o_blue_group2_quarters(o_blue_group2_quarters), .o_gain_code(o_gain_code),
	.o_gain_db(o_gain_db), .o_adc_source(o_adc_source),
	.o_sel_single_ended_audio_pin(o_sel_single_ended_audio_pin),
	.o_sel_temperature(o_sel_temperature), .o_sel_ambient_light(o_sel_ambient_light)
);
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for rgal_top: AHB-Lite accesses against a register model.
// Assumes a 20 MHz clock; the slave's hreadyout is fed back as hready.
`include "rgal_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic             clk, rst, hsel, hwrite;
	logic [1:0]       htrans;
	logic [31:0]      haddr, hwdata, rd, v;
	logic [7:0]       m [3];
	logic [31:0]      adr [3];
	int               checks, miscompares, cycles;
	wire logic [31:0] hrdata;
	wire logic        hready, resp, fm, agc, syn, sa, st, sl, avg;
	wire logic [1:0]  rc, gc, bc, src, filt, spd;
	wire logic [2:0]  rq, gq, bq, gcode;
	wire logic [4:0]  gdb;

	rgal_top dut (
		.i_ref_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(resp),
		.o_red_group2_ceiling(rc), .o_green_group2_ceiling(gc), .o_blue_group2_ceiling(bc),
		.o_red_group2_quarters(rq), .o_green_group2_quarters(gq), .o_blue_group2_quarters(bq),
		.o_gain_code(gcode), .o_gain_db(gdb), .o_freq_mode(fm), .o_agc_enable(agc),
		.o_sync_enable(syn), .o_adc_source(src), .o_sel_single_ended_audio_pin(sa),
		.o_sel_temperature(st), .o_sel_ambient_light(sl), .o_avg_enable(avg),
		.o_filter_scheme(filt), .o_response_speed(spd)
	);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input int k, input logic [7:0] d);
		v = $urandom;
		bus(adr[k], 1'b1, {v[31:8], d});
		m[k] = k == 2 ? d & 8'h1F : d;
	endtask

	task automatic regs;
		for (int k = 0; k < 3; k++) begin
			bus(adr[k], 1'b0, 32'h0);
			chk("register", {24'h0, m[k]}, rd);
			chk("response", 32'h0, {31'h0, resp});
		end
		bus({22'h0, `RGAL_IDX_STAT, 2'b00}, 1'b0, 32'h0);
		chk("status", {24'h0, 1'b0, m[1][7:5] * 5'h03, m[1][1:0]}, rd);
	endtask

	task automatic outs;
		chk("ceilings", m[0][5:0], {rc, gc, bc});
		chk("red quarters", m[0][5:4] + 1, rq);
		chk("green quarters", m[0][3:2] + 1, gq);
		chk("blue quarters", m[0][1:0] + 1, bq);
		chk("gain code", m[1][7:5], gcode);
		chk("gain dB", m[1][7:5] * 3, gdb);
		chk("freq mode", m[1][4], fm);
		chk("agc", m[1][3], agc);
		chk("sync", m[1][2], syn);
		chk("source", m[1][1:0], src);
		chk("selects", m[1][1:0] == 2'b11 ? 0 : 1 << m[1][1:0], {sl, st, sa});
		chk("averaging", m[2][4], avg);
		chk("filter", m[2][3:2], filt);
		chk("speed", m[2][1:0], spd);
	endtask

	task automatic do_reset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		m = '{8'h00, 8'h03, 8'h00};
	endtask

	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			stop_test;
		end
	end

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		adr = '{{22'h0, `RGAL_IDX_RGB2, 2'b00}, {22'h0, `RGAL_IDX_AUD1, 2'b00},
			{22'h0, `RGAL_IDX_AUD2, 2'b00}};
		v = $urandom(32'hc464);
		do_reset;
		regs;
		outs;
		$display("test reset values done");
		for (int i = 0; i < 8; i++) begin
			wr(0, {v[7:6], i[1:0], i[1:0] + 2'd1, ~i[1:0]});
			wr(1, {i[2:0], v[4:2], i[1:0]});
			wr(2, {v[7:4], i[1:0], ~i[1:0]});
			regs;
			outs;
		end
		$display("test codes done");
		bus(32'h0000_0050, 1'b1, v);
		bus(32'h0000_0050, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(32'h0000_04A8, 1'b1, ~v);
		bus({22'h0, `RGAL_IDX_STAT, 2'b00}, 1'b1, v);
		regs;
		$display("test unmapped done");
		do_reset;
		regs;
		outs;
		$display("test second reset done");
		stop_test;
	end
endmodule // tb
`default_nettype wire
